// [inc/io_space_defines.svh]
// io_space_defines.svh - offsets, field masks, reset values and timing counts of the i/o register space
`ifndef IO_SPACE_DEFINES_SVH
`define IO_SPACE_DEFINES_SVH

// ****************************************
// address map edges
// ****************************************
`define IO_DIRECT_LAST 8'h3F
`define IO_BIT_LAST 8'h1F
`define DATA_IO_OFFSET 8'h20
`define DATA_IO_LAST 8'h5F
`define EXT_FIRST 8'h60

// ****************************************
// register offsets in i/o numbering
// ****************************************
`define OFS_PORT_A_PIN_LEVELS 6'h00
`define OFS_PORT_A_DIRECTION 6'h01
`define OFS_PORT_A_OUTPUT 6'h02
`define OFS_PORT_B_PIN_LEVELS 6'h03
`define OFS_PORT_B_DIRECTION 6'h04
`define OFS_PORT_B_OUTPUT 6'h05
`define OFS_PORT_C_PIN_LEVELS 6'h06
`define OFS_PORT_C_DIRECTION 6'h07
`define OFS_PORT_C_OUTPUT 6'h08
`define OFS_PORT_D_PIN_LEVELS 6'h09
`define OFS_PORT_D_DIRECTION 6'h0A
`define OFS_PORT_D_OUTPUT 6'h0B
`define OFS_TIMER_ZERO_FLAGS 6'h15
`define OFS_TIMER_ONE_FLAGS 6'h16
`define OFS_TIMER_TWO_FLAGS 6'h17
`define OFS_TIMER_THREE_FLAGS 6'h18
`define OFS_PIN_CHANGE_FLAGS 6'h1B
`define OFS_EXTERNAL_IRQ_FLAGS 6'h1C
`define OFS_SCRATCH_ZERO 6'h1E
`define OFS_EEPROM_CONTROL 6'h1F
`define OFS_EEPROM_DATA 6'h20
`define OFS_EEPROM_ADDR_LOW 6'h21
`define OFS_EEPROM_ADDR_HIGH 6'h22
`define OFS_GLOBAL_TIMER_CONTROL 6'h23
`define OFS_TIMER_ZERO_CONTROL_A 6'h24
`define OFS_TIMER_ZERO_CONTROL_B 6'h25
`define OFS_TIMER_ZERO_COUNT 6'h26
`define OFS_TIMER_ZERO_COMPARE_A 6'h27
`define OFS_TIMER_ZERO_COMPARE_B 6'h28
`define OFS_SCRATCH_ONE 6'h2A
`define OFS_SCRATCH_TWO 6'h2B
`define OFS_SERIAL_PERIPH_CONTROL 6'h2C
`define OFS_SERIAL_PERIPH_STATUS 6'h2D
`define OFS_SERIAL_PERIPH_DATA 6'h2E
`define OFS_COMPARATOR_CONTROL_STATUS 6'h30
`define OFS_DEBUG_MAILBOX 6'h31

// ****************************************
// implemented bits and reset value
// ****************************************
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define MASK_TIMER_FLAGS_NARROW 8'h07
`define MASK_TIMER_FLAGS_WIDE 8'h27
`define MASK_PIN_CHANGE_FLAGS 8'h0F
`define MASK_EXTERNAL_IRQ_FLAGS 8'h07
`define MASK_EEPROM_CONTROL 8'h3F
`define MASK_EEPROM_ADDR_HIGH 8'h0F
`define MASK_GLOBAL_TIMER_CONTROL 8'h83
`define MASK_TIMER_ZERO_CONTROL_A 8'hF3
`define MASK_TIMER_ZERO_CONTROL_B 8'h0F
`define MASK_SERIAL_STATUS_RW 8'h01
`define MASK_COMPARATOR_RW 8'hCF
`define MASK_COMPARATOR_FLAG 8'h10
`define BIT_COMPARATOR_OUT 5
`define RST_VALUE 8'h00
`define FLAG_COUNT 7
`define SYNC_STAGES 2

`endif

// [inc/io_space_pkg.sv]
// io_space_pkg.sv - types shared by the i/o space decoder and its users
`default_nettype none
package io_space_pkg;
  // load and store of every addressing form (direct, indirect, displaced) share the memory ops
  typedef enum logic [2:0] {
    io_read_op,
    io_write_op,
    bit_set_op,
    bit_clear_op,
    skip_if_bit_one_op,
    skip_if_bit_zero_op,
    memory_read_op,
    memory_write_op
  } core_op_type;

  typedef struct packed {
    logic valid;
    core_op_type op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } core_req_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic skip;
    logic [7:0] rdata;
  } core_rsp_type;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } io_write_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ext_cmd_type;
endpackage
`default_nettype wire

// [tb/core_model.sv]
// core_model.sv - behavioural processor core issuing i/o and load/store requests
`default_nettype none
module core_model (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  output var io_space_pkg::core_req_type core_req, // request to the decoder
  input wire io_space_pkg::core_rsp_type core_rsp, // answer from the decoder
  input wire logic core_busy, // decoder stalled by an extended read
  input wire io_space_pkg::ext_cmd_type ext_cmd, // extended-area access seen
  output logic [7:0] ext_rdata, // extended read data
  output var io_space_pkg::ext_cmd_type last_ext // last extended access captured
);
  timeunit 1ns;
  timeprecision 1ns;
  import io_space_pkg::*;
  logic [7:0] roll;

  // ****************************************
  // extended area responder
  // ****************************************
  // outside a read the data line churns, so a late sample never matches by luck
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      roll <= 8'h00;
      last_ext <= '0;
    end else begin
      roll <= roll + 8'h1D;
      if (ext_cmd.valid) begin
        last_ext <= ext_cmd;
      end
    end
  end
  assign ext_rdata = (ext_cmd.valid && !ext_cmd.write) ? (ext_cmd.addr ^ 8'hA5) : roll;

  // ****************************************
  // request issue
  // ****************************************
  initial core_req = '0;

  // reserved i/o numbers, never targeted by this core's i/o or memory writes; bit set and clear are not screened
  function automatic logic reserved_io(input logic [7:0] io);
    return io inside {[8'h0C:8'h14], 8'h19, 8'h1A, 8'h1D, 8'h29, 8'h2F, 8'h32};
  endfunction

  // one request, held for one taking edge, then wait a bounded time for the answer
  task automatic op(input core_op_type o, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] d, output core_rsp_type r);
    int n;
    logic [7:0] io;
    n = 0;
    r = '0;
    io = (o == memory_write_op) ? a - 8'h20 : a;
    if ((o == io_write_op || o == memory_write_op) && reserved_io(io)) begin
      return;
    end
    // one idle edge, so valid is never lowered and raised in the same time step
    @(negedge clk_sys);
    while (core_busy === 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    core_req = '{1'b1, o, a, b, d};
    @(posedge clk_sys);
    @(negedge clk_sys);
    core_req.valid = 1'b0;
    n = 0;
    while (core_rsp.valid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    r = core_rsp;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// tb.sv - self-checking bench for the i/o space decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import io_space_pkg::*;
  logic clk_sys, arst_n, core_busy, acmp_out;
  core_req_type core_req;
  core_rsp_type core_rsp;
  logic [31:0] pin_in, pin_out, pin_oe_n;
  logic [6:0][7:0] flag_event;
  logic [1:0] spi_status;
  io_write_type io_write;
  ext_cmd_type ext_cmd, last_ext;
  logic [7:0] ext_rdata;
  int mismatches = 0;
  int n_tests = 0;
  core_op_type bitops [4] = '{bit_set_op, bit_clear_op, skip_if_bit_one_op, skip_if_bit_zero_op};

  io_space_address_decoder io_space_address_decoder_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .core_req(core_req), .core_rsp(core_rsp), .core_busy(core_busy), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .flag_event(flag_event), .acmp_out(acmp_out),
    .spi_status(spi_status), .io_write(io_write), .ext_cmd(ext_cmd), .ext_rdata(ext_rdata));
  core_model core_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .core_req(core_req),
    .core_rsp(core_rsp), .core_busy(core_busy), .ext_cmd(ext_cmd), .ext_rdata(ext_rdata),
    .last_ext(last_ext));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  // rdata is only defined for reads, so write, bit op and skip answers are judged by valid, refused and skip alone
  task automatic run(input core_op_type o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
                     input logic [7:0] er, input logic ef, input logic es);
    core_rsp_type r;
    core_model_inst.op(o, a, b, d, r);
    check("rsp valid", 32'h0000_0001, {31'h0000_0000, r.valid});
    check("rsp refused", {31'h0000_0000, ef}, {31'h0000_0000, r.refused});
    check("rsp skip", {31'h0000_0000, es}, {31'h0000_0000, r.skip});
    if (o == io_read_op || o == memory_read_op) begin
      check("rsp rdata", {24'h00_0000, er}, {24'h00_0000, r.rdata});
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #(40 * 20000);
    mismatches++;
    results;
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    pin_in = 32'h0000_0000;
    flag_event = '0;
    acmp_out = 1'b0;
    spi_status = 2'b00;
    repeat (10) @(negedge clk_sys);
    check("pin_oe_n reset", 32'hFFFF_FFFF, pin_oe_n);
    check("pin_out reset", 32'h0000_0000, pin_out);
    arst_n = 1'b1;
    @(negedge clk_sys);
    // direct i/o and the data-space alias
    run(io_write_op, 8'h05, 3'd0, 8'hA5, 8'h00, 1'b0, 1'b0);
    run(io_write_op, 8'h04, 3'd0, 8'h0F, 8'h00, 1'b0, 1'b0);
    check("pin_out b", 32'h0000_00A5, {24'h00_0000, pin_out[15:8]});
    check("pin_oe_n b", 32'h0000_00F0, {24'h00_0000, pin_oe_n[15:8]});
    run(io_read_op, 8'h05, 3'd0, 8'h00, 8'hA5, 1'b0, 1'b0);
    run(memory_read_op, 8'h25, 3'd0, 8'h00, 8'hA5, 1'b0, 1'b0);
    run(memory_write_op, 8'h4A, 3'd0, 8'h3C, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h2A, 3'd0, 8'h00, 8'h3C, 1'b0, 1'b0);
    pin_in = 32'h0000_005A;
    acmp_out = 1'b1;
    spi_status = 2'b10;
    repeat (3) @(negedge clk_sys);
    run(io_read_op, 8'h00, 3'd0, 8'h00, 8'h5A, 1'b0, 1'b0);
    run(memory_read_op, 8'h20, 3'd0, 8'h00, 8'h5A, 1'b0, 1'b0);
    run(io_read_op, 8'h30, 3'd0, 8'h00, 8'h20, 1'b0, 1'b0);
    run(io_read_op, 8'h2D, 3'd0, 8'h00, 8'h80, 1'b0, 1'b0);
    $display("test io window done");
    // refusals at every edge of the map
    run(io_read_op, 8'h40, 3'd0, 8'h00, 8'h00, 1'b1, 1'b0);
    run(io_read_op, 8'h60, 3'd0, 8'h00, 8'h00, 1'b1, 1'b0);
    run(memory_read_op, 8'h1F, 3'd0, 8'h00, 8'h00, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run(bitops[i], 8'h20, 3'd0, 8'h00, 8'h00, 1'b1, 1'b0);
    end
    run(io_read_op, 8'h20, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    $display("test refusals done");
    // single-bit set, clear and skip
    run(bit_set_op, 8'h1E, 3'd3, 8'h00, 8'h00, 1'b0, 1'b0);
    run(bit_set_op, 8'h1E, 3'd7, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h1E, 3'd0, 8'h00, 8'h88, 1'b0, 1'b0);
    run(bit_clear_op, 8'h1E, 3'd3, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h1E, 3'd0, 8'h00, 8'h80, 1'b0, 1'b0);
    run(skip_if_bit_one_op, 8'h1E, 3'd7, 8'h00, 8'h00, 1'b0, 1'b1);
    run(skip_if_bit_one_op, 8'h1E, 3'd3, 8'h00, 8'h00, 1'b0, 1'b0);
    run(skip_if_bit_zero_op, 8'h1E, 3'd3, 8'h00, 8'h00, 1'b0, 1'b1);
    run(skip_if_bit_zero_op, 8'h1E, 3'd7, 8'h00, 8'h00, 1'b0, 1'b0);
    $display("test bit ops done");
    // write-one-to-clear flags and the read-modify-write side effect
    flag_event[0] = 8'h07;
    flag_event[4] = 8'hFF;
    @(negedge clk_sys);
    flag_event = '0;
    run(io_read_op, 8'h15, 3'd0, 8'h00, 8'h07, 1'b0, 1'b0);
    run(io_read_op, 8'h1B, 3'd0, 8'h00, 8'h0F, 1'b0, 1'b0);
    run(io_write_op, 8'h15, 3'd0, 8'h02, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h15, 3'd0, 8'h00, 8'h05, 1'b0, 1'b0);
    run(io_write_op, 8'h15, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h15, 3'd0, 8'h00, 8'h05, 1'b0, 1'b0);
    run(bit_set_op, 8'h15, 3'd1, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h15, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(bit_clear_op, 8'h1B, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h1B, 3'd0, 8'h00, 8'h01, 1'b0, 1'b0);
    $display("test flags done");
    // extended area by load and store only
    run(memory_write_op, 8'h60, 3'd0, 8'h3C, 8'h00, 1'b0, 1'b0);
    @(negedge clk_sys);
    check("ext write", 32'h0003_603C, {14'h0000, last_ext});
    run(memory_read_op, 8'h7A, 3'd0, 8'h00, 8'hDF, 1'b0, 1'b0);
    check("ext read", 32'h0002_0000, {14'h0000, last_ext.valid, last_ext.write, 16'h0000});
    check("ext addr", 32'h0000_007A, {24'h00_0000, last_ext.addr});
    run(io_write_op, 8'h60, 3'd0, 8'h11, 8'h00, 1'b1, 1'b0);
    @(negedge clk_sys);
    check("ext untouched", 32'h0000_007A, {24'h00_0000, last_ext.addr});
    $display("test extended area done");
    // reserved locations read zero
    run(io_read_op, 8'h0C, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(memory_read_op, 8'h4F, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(io_read_op, 8'h32, 3'd0, 8'h00, 8'h00, 1'b0, 1'b0);
    $display("test reserved done");
    results;
  end
endmodule
`default_nettype wire

// [verilog/flag_reg.sv]
// flag_reg.sv - one byte of sticky status flags, cleared by writing one
`include "io_space_defines.svh"
`default_nettype none
module flag_reg (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] impl_mask, // implemented flag bits
  input wire logic [7:0] set_evt, // hardware events, one cycle each
  input wire logic [7:0] clr_bits, // ones written by the core
  output logic [7:0] flags // current flags
);
  // a set arriving with its clear wins so no event is lost; zeros leave flags alone
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `RST_VALUE;
    end else begin
      flags <= ((flags & ~clr_bits) | set_evt) & impl_mask;
    end
  end
endmodule
`default_nettype wire

// [verilog/io_space_address_decoder.sv]
// io_space_address_decoder.sv - decoder and register bank of the processor i/o space
//
// How it works
// - bit set and clear act only on i/o locations 0x00 to 0x1F; higher are refused.
// - on those locations the core may test one bit and skip on one or zero.
// - status flags clear when a one is written; a zero leaves them unchanged.
// - bit set and clear rewrite the whole register, so set flags read back clear, save the bit that a bit clear targets.
// - i/o read and write instructions reach only i/o locations 0 to 63.
// - load and store reach each i/o register at its i/o address plus 0x20.
// - extended area 0x60 to 0xFF is reached by load and store only.
`include "io_space_defines.svh"
`default_nettype none
module io_space_address_decoder (
  input wire logic clk_sys, // core clock, 25 MHz
  input wire logic arst_n, // async reset, active low
  input wire io_space_pkg::core_req_type core_req, // access from the core
  output io_space_pkg::core_rsp_type core_rsp, // answer, one cycle later, two cycles for extended reads
  output logic core_busy, // extended read in flight, new request not taken
  input wire logic [31:0] pin_in, // port pins, d:c:b:a
  output logic [31:0] pin_out, // port output levels
  output logic [31:0] pin_oe_n, // port output enable, low drives
  input wire logic [6:0][7:0] flag_event, // flag set pulses per flag register
  input wire logic acmp_out, // comparator output level
  input wire logic [1:0] spi_status, // serial status bits, level
  output io_space_pkg::io_write_type io_write, // write pulse to peripherals
  output io_space_pkg::ext_cmd_type ext_cmd, // extended-area access
  input wire logic [7:0] ext_rdata // extended read data during ext_cmd
);
  import io_space_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************

  // bits that software may store in each location
  function automatic logic [7:0] write_mask(input logic [5:0] a);
    case (a)
      `OFS_PORT_A_DIRECTION, `OFS_PORT_A_OUTPUT, `OFS_PORT_B_DIRECTION, `OFS_PORT_B_OUTPUT,
      `OFS_PORT_C_DIRECTION, `OFS_PORT_C_OUTPUT, `OFS_PORT_D_DIRECTION, `OFS_PORT_D_OUTPUT,
      `OFS_SCRATCH_ZERO, `OFS_SCRATCH_ONE, `OFS_SCRATCH_TWO, `OFS_EEPROM_DATA,
      `OFS_EEPROM_ADDR_LOW, `OFS_TIMER_ZERO_COUNT, `OFS_TIMER_ZERO_COMPARE_A,
      `OFS_TIMER_ZERO_COMPARE_B, `OFS_SERIAL_PERIPH_CONTROL, `OFS_SERIAL_PERIPH_DATA,
      `OFS_DEBUG_MAILBOX: write_mask = `MASK_FULL;
      `OFS_EEPROM_CONTROL: write_mask = `MASK_EEPROM_CONTROL;
      `OFS_EEPROM_ADDR_HIGH: write_mask = `MASK_EEPROM_ADDR_HIGH;
      `OFS_GLOBAL_TIMER_CONTROL: write_mask = `MASK_GLOBAL_TIMER_CONTROL;
      `OFS_TIMER_ZERO_CONTROL_A: write_mask = `MASK_TIMER_ZERO_CONTROL_A;
      `OFS_TIMER_ZERO_CONTROL_B: write_mask = `MASK_TIMER_ZERO_CONTROL_B;
      `OFS_SERIAL_PERIPH_STATUS: write_mask = `MASK_SERIAL_STATUS_RW;
      `OFS_COMPARATOR_CONTROL_STATUS: write_mask = `MASK_COMPARATOR_RW;
      default: write_mask = `MASK_NONE;
    endcase
  endfunction

  // which flag register a location holds, FLAG_COUNT when none
  function automatic logic [2:0] flag_index(input logic [5:0] a);
    case (a)
      `OFS_TIMER_ZERO_FLAGS: flag_index = 3'd0;
      `OFS_TIMER_ONE_FLAGS: flag_index = 3'd1;
      `OFS_TIMER_TWO_FLAGS: flag_index = 3'd2;
      `OFS_TIMER_THREE_FLAGS: flag_index = 3'd3;
      `OFS_PIN_CHANGE_FLAGS: flag_index = 3'd4;
      `OFS_EXTERNAL_IRQ_FLAGS: flag_index = 3'd5;
      `OFS_COMPARATOR_CONTROL_STATUS: flag_index = 3'd6;
      default: flag_index = 3'(`FLAG_COUNT);
    endcase
  endfunction

  function automatic logic [7:0] flag_mask(input int i);
    case (i)
      0, 2: flag_mask = `MASK_TIMER_FLAGS_NARROW;
      1, 3: flag_mask = `MASK_TIMER_FLAGS_WIDE;
      4: flag_mask = `MASK_PIN_CHANGE_FLAGS;
      5: flag_mask = `MASK_EXTERNAL_IRQ_FLAGS;
      default: flag_mask = `MASK_COMPARATOR_FLAG;
    endcase
  endfunction

  // pin level locations: port index, or 3'd4 when not a pin register
  function automatic logic [2:0] pin_index(input logic [5:0] a);
    case (a)
      `OFS_PORT_A_PIN_LEVELS: pin_index = 3'd0;
      `OFS_PORT_B_PIN_LEVELS: pin_index = 3'd1;
      `OFS_PORT_C_PIN_LEVELS: pin_index = 3'd2;
      `OFS_PORT_D_PIN_LEVELS: pin_index = 3'd3;
      default: pin_index = 3'd4;
    endcase
  endfunction

  function automatic logic is_implemented(input logic [5:0] a);
    is_implemented = (write_mask(a) != `MASK_NONE) || (flag_index(a) != 3'(`FLAG_COUNT)) ||
                     (pin_index(a) != 3'd4) || (a == `OFS_SERIAL_PERIPH_STATUS);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0] io_store [0:63];
  logic [7:0] flags [0:6];
  logic [31:0] pin_level;
  logic ext_wait;
  logic taken;
  logic hit_io;
  logic hit_ext;
  logic refuse;
  logic writes;
  logic do_write;
  logic [5:0] io_addr;
  logic [7:0] cur;
  logic [7:0] bit_onehot;
  logic [7:0] next_wdata;
  logic [2:0] sel_flag;

  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_async(pin_in),
    .pin_level(pin_level)
  );

  // ****************************************
  // address decode
  // ****************************************

  // a request waiting for an extended read is not taken; core_busy tells the core
  assign taken = core_req.valid && !ext_wait;
  assign core_busy = ext_wait;
  assign bit_onehot = 8'h01 << core_req.bit_sel;

  // classify the access and find its i/o location
  always_comb begin
    hit_io = 1'b0;
    hit_ext = 1'b0;
    io_addr = core_req.addr[5:0];
    writes = 1'b0;
    case (core_req.op)
      io_read_op, io_write_op: begin
        hit_io = (core_req.addr <= `IO_DIRECT_LAST);
        writes = (core_req.op == io_write_op);
      end
      bit_set_op, bit_clear_op: begin
        hit_io = (core_req.addr <= `IO_BIT_LAST);
        writes = 1'b1;
      end
      skip_if_bit_one_op, skip_if_bit_zero_op: begin
        hit_io = (core_req.addr <= `IO_BIT_LAST);
      end
      memory_read_op, memory_write_op: begin
        io_addr = 6'(core_req.addr - `DATA_IO_OFFSET);
        hit_io = (core_req.addr >= `DATA_IO_OFFSET) && (core_req.addr <= `DATA_IO_LAST);
        hit_ext = (core_req.addr >= `EXT_FIRST);
        writes = (core_req.op == memory_write_op);
      end
      default: begin
        hit_io = 1'b0;
      end
    endcase
    refuse = !(hit_io || hit_ext);
  end

  // current contents of the addressed location; reserved bits and locations read zero
  always_comb begin
    sel_flag = flag_index(io_addr);
    cur = io_store[io_addr] & write_mask(io_addr);
    if (sel_flag != 3'(`FLAG_COUNT)) begin
      cur = cur | flags[sel_flag];
    end
    if (pin_index(io_addr) != 3'd4) begin
      cur = pin_level[pin_index(io_addr) * 8 +: 8];
    end
    if (io_addr == `OFS_COMPARATOR_CONTROL_STATUS) begin
      cur[`BIT_COMPARATOR_OUT] = acmp_out;
    end
    if (io_addr == `OFS_SERIAL_PERIPH_STATUS) begin
      cur[7:6] = spi_status;
    end
  end

  // bit ops write back the whole byte as read, so set flags other than a bit clear's target are written as one
  always_comb begin
    case (core_req.op)
      bit_set_op: next_wdata = cur | bit_onehot;
      bit_clear_op: next_wdata = cur & ~bit_onehot;
      default: next_wdata = core_req.wdata;
    endcase
  end

  // writes to reserved locations are dropped and raise no peripheral pulse
  assign do_write = taken && hit_io && writes && is_implemented(io_addr);

  // ****************************************
  // register storage
  // ****************************************

  // only implemented bits are stored, the rest stays zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 64; i++) begin
        io_store[i] <= `RST_VALUE;
      end
    end else if (do_write) begin
      io_store[io_addr] <= next_wdata & write_mask(io_addr);
    end
  end

  // sticky flags, cleared by the ones in a write
  for (genvar g = 0; g < `FLAG_COUNT; g++) begin : g_flag
    flag_reg u_flag (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .impl_mask(flag_mask(g)),
      .set_evt(flag_event[g]),
      .clr_bits((do_write && sel_flag == 3'(g)) ? next_wdata : `MASK_NONE),
      .flags(flags[g])
    );
  end

  // ****************************************
  // port pins
  // ****************************************

  // pins follow the stored direction and output bytes directly
  always_comb begin
    pin_out = {io_store[`OFS_PORT_D_OUTPUT], io_store[`OFS_PORT_C_OUTPUT],
               io_store[`OFS_PORT_B_OUTPUT], io_store[`OFS_PORT_A_OUTPUT]};
    pin_oe_n = ~{io_store[`OFS_PORT_D_DIRECTION], io_store[`OFS_PORT_C_DIRECTION],
                 io_store[`OFS_PORT_B_DIRECTION], io_store[`OFS_PORT_A_DIRECTION]};
  end

  // ****************************************
  // answers and pulses
  // ****************************************

  // answer one cycle after the request; extended reads answer one cycle later still
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      core_rsp <= '0;
    end else if (ext_wait) begin
      core_rsp <= '{valid: 1'b1, refused: 1'b0, skip: 1'b0, rdata: ext_rdata};
    end else if (taken && !(hit_ext && !writes)) begin
      core_rsp.valid <= 1'b1;
      core_rsp.refused <= refuse;
      core_rsp.rdata <= (hit_io && !writes) ? cur : `RST_VALUE;
      core_rsp.skip <= hit_io && ((core_req.op == skip_if_bit_one_op && (cur & bit_onehot) != 8'h00) ||
                       (core_req.op == skip_if_bit_zero_op && (cur & bit_onehot) == 8'h00));
    end else begin
      core_rsp <= '0;
    end
  end

  // extended area goes out as a registered command; reads hold off the next request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_cmd <= '0;
      ext_wait <= 1'b0;
    end else begin
      ext_cmd.valid <= taken && hit_ext;
      ext_cmd.write <= writes;
      ext_cmd.addr <= core_req.addr;
      ext_cmd.wdata <= core_req.wdata;
      ext_wait <= taken && hit_ext && !writes;
    end
  end

  // peripherals see every effective write, strobe bits included
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_write <= '0;
    end else begin
      io_write.valid <= do_write;
      io_write.addr <= io_addr;
      io_write.data <= next_wdata;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_bit_op_range: assert property (
    (taken && (core_req.op inside {bit_set_op, bit_clear_op}) && core_req.addr > `IO_BIT_LAST)
    |=> (core_rsp.refused && !io_write.valid))
    else $error("bit op above 0x1F was not refused");

  a_skip_on_one: assert property (
    (taken && core_req.op == skip_if_bit_one_op && core_req.addr <= `IO_BIT_LAST
     && (cur & bit_onehot) != 8'h00) |=> core_rsp.skip)
    else $error("skip on set bit missing");

  a_flag_write_clears: assert property (
    (do_write && sel_flag == 3'd0 && next_wdata[0] && !flag_event[0][0]) |=> !flags[0][0])
    else $error("written one did not clear flag");

  // a refused bit op at an aliasing number must not count, so the whole address is compared
  a_bit_op_rewrites: assert property (
    (taken && core_req.op == bit_set_op && core_req.addr == {2'b00, `OFS_TIMER_ZERO_FLAGS}
     && core_req.bit_sel != 3'd0 && flags[0][0] && !flag_event[0][0]) |=> !flags[0][0])
    else $error("bit set left a set flag standing");

  a_io_op_window: assert property (
    (taken && (core_req.op inside {io_read_op, io_write_op}) && core_req.addr > `IO_DIRECT_LAST)
    |=> core_rsp.valid && core_rsp.refused && !ext_cmd.valid)
    else $error("i/o op beyond 64 locations accepted");

  a_data_alias: assert property (
    (taken && core_req.op == memory_write_op && core_req.addr == 8'h4A)
    |=> io_write.valid && io_write.addr == `OFS_SCRATCH_ONE)
    else $error("data alias not at i/o address plus 0x20");

  a_ext_by_memory: assert property (
    (taken && core_req.op == memory_read_op && core_req.addr >= `EXT_FIRST)
    |=> ext_cmd.valid && !ext_cmd.write && core_busy ##1 core_rsp.valid && core_rsp.rdata == $past(ext_rdata))
    else $error("extended read not carried out");

  a_reserved_zero: assert property (
    (taken && core_req.op == io_read_op && core_req.addr[5:0] == 6'h32) |=> core_rsp.rdata == 8'h00)
    else $error("reserved location read nonzero");

  c_bit_clear: cover property (taken && core_req.op == bit_clear_op && hit_io);
  c_skip_zero: cover property (taken && core_req.op == skip_if_bit_zero_op ##1 core_rsp.skip);
  c_ext_write: cover property (taken && core_req.op == memory_write_op && hit_ext);
endmodule
`default_nettype wire

// [verilog/pin_sync.sv]
// pin_sync.sv - two-stage synchroniser for the port pin levels
`include "io_space_defines.svh"
`default_nettype none
module pin_sync (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic [31:0] pin_async, // raw pin levels
  output logic [31:0] pin_level // synchronised levels
);
  logic [31:0] stage_one;

  // first stage feeds only the second, which absorbs metastability
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage_one <= 32'h0000_0000;
      pin_level <= 32'h0000_0000;
    end else begin
      stage_one <= pin_async;
      pin_level <= stage_one;
    end
  end
endmodule
`default_nettype wire
